// [include/entry_seq_cfg.svh]
// Constants of the entry and cursor sequencer.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef ENTRY_SEQ_CFG_SVH
`define ENTRY_SEQ_CFG_SVH

`define CLK_PERIOD_NS      10
`define CLK_RATE_HZ        100000000
`define PHASE_PERIOD_NS    700
`define PHASE_PERIOD_CYC   (`PHASE_PERIOD_NS / `CLK_PERIOD_NS)
`define PHASE_SPACING_CYC  8
`define PHASE_CNT_LAST     7'h45
`define REPEAT_RATE_HZ     15
`define REPEAT_CYC         (`CLK_RATE_HZ / `REPEAT_RATE_HZ)
`define LAST_COLUMN        7'h49
`define LAST_ROW           5'h1a
`define STEP_COUNT         7
`define STEP_FIRST         7'h01
`define STEP_NONE          7'h00
`define BRIGHT_BIT         7
`define CTRL_DECODE_HI     6
`define CTRL_DECODE_LO     5
`define DATA_CLEAR         8'h00

`endif

// [include/entry_seq_pkg.sv]
// Types of the entry and cursor sequencer.
// Assumes entry_seq_cfg.svh for the numeric constants.
package entry_seq_pkg;

  typedef logic [6:0] column_type;
  typedef logic [4:0] row_type;

  // Function requests from keyboard and host logic
  typedef struct packed {
    logic carriage_return;
    logic cursor_left;
    logic cursor_right;
    logic cursor_up;
    logic cursor_down;
    logic cursor_home;
    logic key_repeat;
    logic host_backspace_seen;
    logic host_return_after_leadin;
    logic xmit_print_active;
  } cmd_type;

  // Direct cursor access by the host
  typedef struct packed {
    logic       host_column_clear;
    logic       host_row_clear;
    logic       load;
    column_type column;
    row_type    row;
  } host_cursor_type;

  typedef enum logic [2:0] {
    SEQ_IDLE     = 3'h0,
    SEQ_ARMED    = 3'h1,
    SEQ_STAGE_A  = 3'h3,
    SEQ_STAGE_B  = 3'h2,
    SEQ_RUN      = 3'h6,
    SEQ_RPT_WAIT = 3'h7
  } seq_state_type;

endpackage

// [verilog/terminal_entry_cursor_sequencer.sv]
// Seven-step sequencer for character entry, return, cursor motion and home.
// Assumes keyboard and host logic on clk_sys_i; memory answers bright bit
// for the addressed cell while a read/restore is issued.
`timescale 1ns/10ps
`include "entry_seq_cfg.svh"

// Function
// [R1] Keyboard strobe arms batch mode; host entry request arms receive mode.
// [R2] Armed, line tick sets entry flop; first phase-zero clears data register.
// [R3] Next phase-zero loads seven keyboard bits and arms step one.
// [R4] Keyboard characters get the bright bit set to one.
// [R5] Seven steps advance on phase-one pulses; unused steps do nothing.
// [R6] Receive: step one clears data on phase four, loads host byte on six.
// [R7] Step two issues read/restore unless transmit or print is active; the code also skips it for cursor home.
// [R8] Step three writes eight bits; keyboard only over bright cells.
// [R9] Entry step four increments column except at last column and row.
// [R10] Entry at last column carries into the row counter.
// [R11] Carriage return is stored, then cursor returns and feeds a line.
// [R12] Return after lead-in code skips the write but still moves.
// [R13] Refresh blanks cells whose bits six and seven decode a control code; the code decodes bits six and five.
// [R14] Return step four increments row unless last and clears column.
// [R15] Cursor left: step three idle; step four decrements nonzero column.
// [R16] Direction keys move one step to limits; repeat recycles at 15 Hz.
// [R17] Host backspace acts exactly like cursor left.
// [R18] Host cursor addressing loads the counters without the sequencer.
// [R19] Home goes to zero; host home clears counters directly.
// [R20] Keyboard home clears both counters at step four on phase one.
// [R21] After step seven return to idle unless repeat asks another cycle.
module terminal_entry_cursor_sequencer
#(
  parameter int unsigned REPEAT_CYCLES = `REPEAT_CYC
)
(
  input  wire logic                           clk_sys_i,
  input  wire logic                           reset_i,
  input  wire logic                           keyboard_entry_strobe_i,
  input  wire logic                           host_entry_request_i,
  input  wire logic                           line_drive_tick_i,
  input  wire logic [6:0]                     keyboard_data_i,
  input  wire logic [7:0]                     host_data_i,
  input  wire logic                           host_data_pending_i,
  input  wire entry_seq_pkg::cmd_type         cmd_i,
  input  wire entry_seq_pkg::host_cursor_type host_cursor_i,
  input  wire logic                           mem_bright_i,
  input  wire logic [7:0]                     refresh_char_i,
  output logic                                mem_read_restore_o,
  output logic                                mem_write_o,
  output logic [7:0]                          mem_data_o,
  output entry_seq_pkg::column_type           cursor_column_counter_o,
  output entry_seq_pkg::row_type              cursor_row_counter_o,
  output logic [6:0]                          step_o,
  output logic                                busy_o,
  output logic                                refresh_blank_o
);
  import entry_seq_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Timing phases

  logic [6:0]    phase_cnt_q;
  logic          phase_zero_pulse;
  logic          phase_one_pulse;
  logic          phase_three_pulse;
  logic          phase_four_pulse;
  logic          phase_six_pulse;
  seq_state_type state_q;
  logic [6:0]    step_q;
  cmd_type       cmd_q;
  logic          mode_host_q;
  logic [7:0]    data_q;
  column_type    col_q;
  row_type       row_q;
  column_type    col_d;
  row_type       row_d;
  logic [31:0]   repeat_cnt_q;
  logic          repeat_done;
  logic          repeat_held;
  logic          run;
  logic          move_left;
  logic          entry_char;
  logic          cursor_count_pulse;
  logic          column_increment_enable;
  logic          column_decrement_enable;
  logic          home_clear;

  function automatic logic phase_hit(input logic [6:0] cnt, input int unsigned k);
    phase_hit = (cnt == 7'(k * `PHASE_SPACING_CYC));
  endfunction

  function automatic logic at_corner(input column_type c, input row_type r);
    at_corner = (c == `LAST_COLUMN) && (r == `LAST_ROW);
  endfunction

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || phase_cnt_q == `PHASE_CNT_LAST)
      phase_cnt_q <= 7'h00;
    else
      phase_cnt_q <= phase_cnt_q + 7'h01;
  end

  assign phase_zero_pulse  = phase_hit(phase_cnt_q, 0);
  assign phase_one_pulse   = phase_hit(phase_cnt_q, 1);
  assign phase_three_pulse = phase_hit(phase_cnt_q, 3);
  assign phase_four_pulse  = phase_hit(phase_cnt_q, 4);
  assign phase_six_pulse   = phase_hit(phase_cnt_q, 6);

  //////////////////////////////////////////////////////////////////////////
  // Entry control and step counter

  assign run         = (state_q == SEQ_RUN);
  assign repeat_held = cmd_i.key_repeat &&
                       (cmd_i.cursor_left || cmd_i.cursor_right ||
                        cmd_i.cursor_up || cmd_i.cursor_down);
  assign repeat_done = (repeat_cnt_q >= REPEAT_CYCLES - 1);

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      state_q     <= SEQ_IDLE;
      step_q      <= `STEP_NONE;
      cmd_q       <= '0;
      mode_host_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        SEQ_IDLE:
        begin
          if (keyboard_entry_strobe_i || host_entry_request_i)
          begin
            state_q     <= SEQ_ARMED;                              // [R1]
            mode_host_q <= !keyboard_entry_strobe_i;               // [R1]
            cmd_q       <= cmd_i;
          end
        end
        SEQ_ARMED:
          if (line_drive_tick_i)
            state_q <= SEQ_STAGE_A;                                // [R2]
        SEQ_STAGE_A:
          if (phase_zero_pulse)
            state_q <= SEQ_STAGE_B;                                // [R2]
        SEQ_STAGE_B:
          if (phase_zero_pulse)
            state_q <= SEQ_RUN;                                    // [R3]
        SEQ_RUN:
        begin
          if (phase_one_pulse)
          begin
            if (step_q == `STEP_NONE)
              step_q <= `STEP_FIRST;                               // [R5]
            else if (step_q[`STEP_COUNT-1])
            begin
              step_q  <= `STEP_NONE;
              state_q <= repeat_held ? SEQ_RPT_WAIT : SEQ_IDLE;    // [R21] [R16]
            end
            else
              step_q <= step_q << 1;                               // [R5]
          end
        end
        SEQ_RPT_WAIT:
        begin
          if (!repeat_held)
            state_q <= SEQ_IDLE;                                   // [R16]
          else if (repeat_done)
          begin
            state_q <= SEQ_RUN;                                    // [R16]
            cmd_q   <= cmd_i;
          end
        end
        default:
        begin
          state_q <= SEQ_IDLE;
          step_q  <= `STEP_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || state_q != SEQ_RPT_WAIT)
      repeat_cnt_q <= 32'h0;
    else
      repeat_cnt_q <= repeat_cnt_q + 32'h1;                        // [R16]
  end

  //////////////////////////////////////////////////////////////////////////
  // Data register and memory strobes

  assign move_left  = cmd_q.cursor_left || cmd_q.host_backspace_seen;  // [R17]
  assign entry_char = !(move_left || cmd_q.cursor_right || cmd_q.cursor_up ||
                        cmd_q.cursor_down || cmd_q.cursor_home);

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      data_q <= `DATA_CLEAR;
    else if (state_q == SEQ_STAGE_A && phase_zero_pulse)
      data_q <= `DATA_CLEAR;                                       // [R2]
    else if (state_q == SEQ_STAGE_B && phase_zero_pulse && !mode_host_q)
      data_q <= {1'b1, keyboard_data_i};                           // [R3] [R4]
    else if (run && step_q[0] && mode_host_q && host_data_pending_i)
    begin
      if (phase_four_pulse)
        data_q <= `DATA_CLEAR;                                     // [R6]
      else if (phase_six_pulse)
        data_q <= host_data_i;                                     // [R6]
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      mem_read_restore_o <= 1'b0;
      mem_write_o        <= 1'b0;
    end
    else
    begin
      mem_read_restore_o <= run && step_q[1] && phase_six_pulse &&
                            !cmd_q.xmit_print_active &&            // [R7]
                            !cmd_q.cursor_home;                    // [R7]
      mem_write_o        <= run && step_q[2] && phase_six_pulse && entry_char &&
                            !cmd_q.host_return_after_leadin &&     // [R12]
                            (mode_host_q || mem_bright_i);         // [R8] [R11]
    end
  end

  assign mem_data_o = data_q;

  //////////////////////////////////////////////////////////////////////////
  // Cursor counters

  assign column_increment_enable = entry_char && !cmd_q.carriage_return &&
                                   !at_corner(col_q, row_q);       // [R9]
  assign column_decrement_enable = move_left && (col_q != 7'h00);  // [R15]
  assign cursor_count_pulse      = run && step_q[3] && phase_three_pulse; // [R15]
  assign home_clear              = run && step_q[3] && phase_one_pulse &&
                                   cmd_q.cursor_home;              // [R20]

  always_comb
  begin
    col_d = col_q;
    row_d = row_q;
    if (cursor_count_pulse)
    begin
      if (entry_char && cmd_q.carriage_return)
      begin
        col_d = 7'h00;                                             // [R14] [R11]
        if (row_q != `LAST_ROW)
          row_d = row_q + 5'h01;                                   // [R14]
      end
      else if (column_increment_enable)
      begin
        if (col_q == `LAST_COLUMN)
        begin
          col_d = 7'h00;
          row_d = row_q + 5'h01;                                   // [R10]
        end
        else
          col_d = col_q + 7'h01;                                   // [R9]
      end
      else if (column_decrement_enable)
        col_d = col_q - 7'h01;                                     // [R15] [R17]
      else if (cmd_q.cursor_right && col_q != `LAST_COLUMN)
        col_d = col_q + 7'h01;                                     // [R16]
      else if (cmd_q.cursor_up && row_q != 5'h00)
        row_d = row_q - 5'h01;                                     // [R16]
      else if (cmd_q.cursor_down && row_q != `LAST_ROW)
        row_d = row_q + 5'h01;                                     // [R16]
    end
    if (home_clear)
    begin
      col_d = 7'h00;                                               // [R19] [R20]
      row_d = 5'h00;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      col_q <= 7'h00;
      row_q <= 5'h00;
    end
    else if (host_cursor_i.load)
    begin
      col_q <= host_cursor_i.column;                               // [R18]
      row_q <= host_cursor_i.row;
    end
    else
    begin
      col_q <= host_cursor_i.host_column_clear ? 7'h00 : col_d;    // [R19]
      row_q <= host_cursor_i.host_row_clear ? 5'h00 : row_d;       // [R19]
    end
  end

  assign cursor_column_counter_o = col_q;
  assign cursor_row_counter_o    = row_q;
  assign step_o                  = step_q;

  //////////////////////////////////////////////////////////////////////////
  // Status and refresh blanking

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      busy_o          <= 1'b0;
      refresh_blank_o <= 1'b0;
    end
    else
    begin
      busy_o          <= (state_q != SEQ_IDLE);
      refresh_blank_o <= (refresh_char_i[`CTRL_DECODE_HI:`CTRL_DECODE_LO]
                          == 2'b00);                               // [R13]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  a_arm_on_strobe: assert property ( // [R1]
    @(posedge clk_sys_i) disable iff (reset_i)
    state_q == SEQ_IDLE && keyboard_entry_strobe_i
    |=> state_q == SEQ_ARMED && !mode_host_q)
    else $error("keyboard strobe did not arm batch entry");

  a_entry_on_tick: assert property ( // [R2]
    @(posedge clk_sys_i) disable iff (reset_i)
    state_q == SEQ_ARMED && line_drive_tick_i |=> state_q == SEQ_STAGE_A)
    else $error("line tick did not set entry control");

  a_stage_a_clear: assert property ( // [R2]
    @(posedge clk_sys_i) disable iff (reset_i)
    state_q == SEQ_STAGE_A && phase_zero_pulse
    |=> data_q == `DATA_CLEAR && state_q == SEQ_STAGE_B)
    else $error("first stage did not clear data register");

  a_kb_load_bright: assert property ( // [R3] [R4]
    @(posedge clk_sys_i) disable iff (reset_i)
    state_q == SEQ_STAGE_B && phase_zero_pulse && !mode_host_q
    |=> data_q == {1'b1, $past(keyboard_data_i)} && state_q == SEQ_RUN)
    else $error("keyboard byte not loaded with bright bit");

  a_step_onehot: assert property ( // [R5]
    @(posedge clk_sys_i) disable iff (reset_i)
    run && phase_one_pulse && step_q[2] |=> step_q[3] && $onehot(step_q))
    else $error("step counter did not advance in order");

  a_host_load: assert property ( // [R6]
    @(posedge clk_sys_i) disable iff (reset_i)
    run && step_q[0] && mode_host_q && host_data_pending_i && phase_six_pulse
    |=> data_q == $past(host_data_i))
    else $error("host byte not loaded in step one");

  a_rr_in_step2: assert property ( // [R7]
    @(posedge clk_sys_i) disable iff (reset_i)
    mem_read_restore_o |-> $past(step_q[1]) && !$past(cmd_q.xmit_print_active) &&
    !$past(cmd_q.cursor_home))
    else $error("read/restore outside step two");

  a_kb_write_bright: assert property ( // [R8]
    @(posedge clk_sys_i) disable iff (reset_i)
    mem_write_o && !mode_host_q |-> $past(mem_bright_i) && $past(step_q[2]))
    else $error("keyboard write over dim cell");

  a_leadin_nowrite: assert property ( // [R12]
    @(posedge clk_sys_i) disable iff (reset_i)
    cmd_q.host_return_after_leadin && run |=> !mem_write_o)
    else $error("write after lead-in return");

  a_corner_hold: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (reset_i)
    cursor_count_pulse && entry_char && !cmd_q.carriage_return &&
    at_corner(col_q, row_q) && !host_cursor_i.load &&
    !host_cursor_i.host_column_clear && !host_cursor_i.host_row_clear
    |=> $stable(col_q) && $stable(row_q))
    else $error("cursor moved past last cell");

  a_left_stop: assert property ( // [R15]
    @(posedge clk_sys_i) disable iff (reset_i)
    cursor_count_pulse && move_left && col_q == 7'h00 &&
    !host_cursor_i.load && !host_cursor_i.host_column_clear
    |=> col_q == 7'h00)
    else $error("column moved left of zero");

  a_return_home: assert property ( // [R14]
    @(posedge clk_sys_i) disable iff (reset_i)
    cursor_count_pulse && entry_char && cmd_q.carriage_return &&
    !host_cursor_i.load |=> col_q == 7'h00)
    else $error("return did not clear column");

  a_home_clear: assert property ( // [R20]
    @(posedge clk_sys_i) disable iff (reset_i)
    home_clear && !host_cursor_i.load |=> col_q == 7'h00 && row_q == 5'h00)
    else $error("home did not clear cursor");

  c_kb_entry: cover property (
    @(posedge clk_sys_i) disable iff (reset_i)
    mem_write_o && !mode_host_q);

  c_host_entry: cover property (
    @(posedge clk_sys_i) disable iff (reset_i)
    mem_write_o && mode_host_q);

  c_repeat_cycle: cover property (
    @(posedge clk_sys_i) disable iff (reset_i)
    state_q == SEQ_RPT_WAIT ##1 state_q == SEQ_RUN);

endmodule

// [verification/entry_partner.sv]
// Model of the keyboard input and host I/O logic, plus the line drive ticks.
// Assumes the bench raises go_kb_i or go_host_i for one cycle at a falling edge.
`timescale 1ns/10ps
module entry_partner
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_kb_i,
  input  wire logic       go_host_i,
  input  wire logic [7:0] char_i,
  input  wire logic       busy_i,
  output logic            kb_strobe_o,
  output logic            host_req_o,
  output logic [6:0]      kb_data_o,
  output logic [7:0]      host_data_o,
  output logic            pending_o,
  output logic            tick_o
);
  logic [5:0] tick_cnt_q;
  logic       held_q;
  logic       seen_q;

  ////////////////////////////////////////////////////////////////////////////
  // Strobes last one cycle; data and pending held until the sequencer goes idle again
  always @(negedge clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt_q  <= 6'h00;
      tick_o      <= 1'b0;
      kb_strobe_o <= 1'b0;
      host_req_o  <= 1'b0;
      kb_data_o   <= 7'h00;
      host_data_o <= 8'h00;
      pending_o   <= 1'b0;
      held_q      <= 1'b0;
      seen_q      <= 1'b0;
    end
    else
    begin
      tick_cnt_q  <= tick_cnt_q + 6'h01;
      tick_o      <= (tick_cnt_q == 6'h3f);
      kb_strobe_o <= go_kb_i;
      host_req_o  <= go_host_i;
      if (go_kb_i | go_host_i)
      begin
        held_q      <= 1'b1;
        kb_data_o   <= char_i[6:0];
        host_data_o <= char_i;
        pending_o   <= go_host_i | pending_o;
      end
      else if (held_q & busy_i)
        seen_q <= 1'b1;
      else if (held_q & seen_q & ~busy_i)
      begin
        // Released lines show the inverse, not the last value
        held_q      <= 1'b0;
        seen_q      <= 1'b0;
        pending_o   <= 1'b0;
        kb_data_o   <= ~kb_data_o;
        host_data_o <= ~host_data_o;
      end
    end
  end
endmodule

// [verification/terminal_entry_cursor_sequencer_tb.sv]
// Self-checking bench for the entry and cursor sequencer.
// Assumes entry_partner as keyboard and host side; bench drives memory bright bit.
`timescale 1ns/10ps
`include "entry_seq_cfg.svh"
module terminal_entry_cursor_sequencer_tb;
  import entry_seq_pkg::*;
  typedef struct packed {
    logic       host;
    logic       bright;
    cmd_type    cmd;
    logic [7:0] char;
    column_type c0;
    row_type    r0;
    column_type c1;
    row_type    r1;
    logic [1:0] nwr;
    logic [1:0] nrr;
    logic [7:0] wd;
  } row_case_type;
  localparam cmd_type NO_CMD = 10'h000;
  localparam cmd_type RET    = 10'h200;
  localparam cmd_type LEFT   = 10'h100;
  localparam cmd_type RIGHT  = 10'h080;
  localparam cmd_type UP     = 10'h040;
  localparam cmd_type DOWN   = 10'h020;
  localparam cmd_type HOME   = 10'h010;
  localparam cmd_type RPT_RT = 10'h088;
  localparam cmd_type BACK   = 10'h004;
  localparam cmd_type RET_LD = 10'h202;
  localparam cmd_type XP     = 10'h001;
  logic            clk_sys_i = 1'b0;
  logic            reset_i = 1'b1;
  logic            go_kb = 1'b0;
  logic            go_host = 1'b0;
  logic [7:0]      char_q = 8'h00;
  cmd_type         cmd = 10'h000;
  host_cursor_type hc = '0;
  logic            bright = 1'b0;
  logic [7:0]      refresh_char = 8'h41;
  logic            kb_strobe, host_req, pending, tick, rr_o, wr_o, busy_o, blank_o;
  logic [6:0]      kb_data, step_o, prev_step;
  logic [7:0]      host_data, mem_data_o, wd;
  column_type      col_o;
  row_type         row_o;
  int              n_mismatch = 0;
  int              comparisons = 0;
  int              n_wr = 0;
  int              n_rr = 0;
  int              n_st = 0;
  int              n;
  column_type      col_seen;
  row_case_type    rows [20];

  always #5 clk_sys_i = ~clk_sys_i;

  entry_partner u_entry_partner (.clk_i(clk_sys_i), .rst_i(reset_i), .go_kb_i(go_kb),
    .go_host_i(go_host), .char_i(char_q), .busy_i(busy_o), .kb_strobe_o(kb_strobe),
    .host_req_o(host_req), .kb_data_o(kb_data), .host_data_o(host_data),
    .pending_o(pending), .tick_o(tick));

  terminal_entry_cursor_sequencer #(.REPEAT_CYCLES(200)) u_terminal_entry_cursor_sequencer (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .keyboard_entry_strobe_i(kb_strobe),
    .host_entry_request_i(host_req), .line_drive_tick_i(tick), .keyboard_data_i(kb_data),
    .host_data_i(host_data), .host_data_pending_i(pending), .cmd_i(cmd),
    .host_cursor_i(hc), .mem_bright_i(bright), .refresh_char_i(refresh_char),
    .mem_read_restore_o(rr_o), .mem_write_o(wr_o), .mem_data_o(mem_data_o),
    .cursor_column_counter_o(col_o), .cursor_row_counter_o(row_o), .step_o(step_o),
    .busy_o(busy_o), .refresh_blank_o(blank_o));

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Memory strobes and step order, sampled where settled
  always @(negedge clk_sys_i)
  begin
    prev_step <= step_o;
    if (!reset_i)
    begin
      if (wr_o === 1'b1)
      begin
        n_wr++;
        wd = mem_data_o;
      end
      if (rr_o === 1'b1)
        n_rr++;
      if (step_o !== prev_step && step_o !== 7'h00)
      begin
        n_st++;
        chk("step", (prev_step === 7'h00) ? 7'h01 : {prev_step[5:0], 1'b0}, step_o);
      end
    end
  end

  task automatic wait_idle;
    n = 0;
    while (busy_o !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while (busy_o !== 1'b0 && n < 3000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("idle", 1, n < 3000);
  endtask

  task automatic place(input column_type c, input row_type r);
    @(negedge clk_sys_i);
    hc <= '{1'b0, 1'b0, 1'b1, c, r};
    @(negedge clk_sys_i);
    hc <= '0;
    chk("loaded column", c, col_o);
    chk("loaded row", r, row_o);
  endtask

  task automatic run_row(input row_case_type r);
    place(r.c0, r.r0);
    cmd <= r.cmd;
    bright <= r.bright;
    char_q <= r.char;
    go_kb <= ~r.host;
    go_host <= r.host;
    n_wr = 0;
    n_rr = 0;
    n_st = 0;
    @(negedge clk_sys_i);
    go_kb <= 1'b0;
    go_host <= 1'b0;
    wait_idle();
    cmd <= NO_CMD;
    chk("column", r.c1, col_o);
    chk("row", r.r1, row_o);
    chk("writes", r.nwr, n_wr);
    chk("steps", 7, n_st);
    if (r.nrr != 2'h3)
      chk("read restore", r.nrr, n_rr);
    if (r.nwr != 2'h0)
      chk("write data", r.wd, wd);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rows[0]  = '{1'b0, 1'b1, NO_CMD, 8'h41, 7'h05, 5'h03, 7'h06, 5'h03, 2'h1, 2'h1, 8'hc1};
    rows[1]  = '{1'b0, 1'b0, NO_CMD, 8'h41, 7'h05, 5'h03, 7'h06, 5'h03, 2'h0, 2'h1, 8'h00};
    rows[2]  = '{1'b0, 1'b1, NO_CMD, 8'h41, 7'h49, 5'h03, 7'h00, 5'h04, 2'h1, 2'h1, 8'hc1};
    rows[3]  = '{1'b0, 1'b1, NO_CMD, 8'h41, 7'h49, 5'h1a, 7'h49, 5'h1a, 2'h1, 2'h1, 8'hc1};
    rows[4]  = '{1'b1, 1'b0, NO_CMD, 8'h42, 7'h05, 5'h03, 7'h06, 5'h03, 2'h1, 2'h1, 8'h42};
    rows[5]  = '{1'b0, 1'b1, RET, 8'h0d, 7'h0a, 5'h05, 7'h00, 5'h06, 2'h1, 2'h1, 8'h8d};
    rows[6]  = '{1'b0, 1'b1, RET, 8'h0d, 7'h0a, 5'h1a, 7'h00, 5'h1a, 2'h1, 2'h1, 8'h8d};
    rows[7]  = '{1'b1, 1'b1, RET_LD, 8'h0d, 7'h0a, 5'h05, 7'h00, 5'h06, 2'h0, 2'h1, 8'h00};
    rows[8]  = '{1'b1, 1'b0, RET, 8'h0d, 7'h0a, 5'h05, 7'h00, 5'h06, 2'h1, 2'h1, 8'h0d};
    rows[9]  = '{1'b0, 1'b1, LEFT, 8'h00, 7'h05, 5'h03, 7'h04, 5'h03, 2'h0, 2'h1, 8'h00};
    rows[10] = '{1'b0, 1'b1, LEFT, 8'h00, 7'h00, 5'h03, 7'h00, 5'h03, 2'h0, 2'h1, 8'h00};
    rows[11] = '{1'b1, 1'b1, BACK, 8'h08, 7'h05, 5'h03, 7'h04, 5'h03, 2'h0, 2'h1, 8'h00};
    rows[12] = '{1'b0, 1'b1, RIGHT, 8'h00, 7'h05, 5'h03, 7'h06, 5'h03, 2'h0, 2'h1, 8'h00};
    rows[13] = '{1'b0, 1'b1, RIGHT, 8'h00, 7'h49, 5'h03, 7'h49, 5'h03, 2'h0, 2'h1, 8'h00};
    rows[14] = '{1'b0, 1'b1, UP, 8'h00, 7'h05, 5'h03, 7'h05, 5'h02, 2'h0, 2'h1, 8'h00};
    rows[15] = '{1'b0, 1'b1, UP, 8'h00, 7'h05, 5'h00, 7'h05, 5'h00, 2'h0, 2'h1, 8'h00};
    rows[16] = '{1'b0, 1'b1, DOWN, 8'h00, 7'h05, 5'h03, 7'h05, 5'h04, 2'h0, 2'h1, 8'h00};
    rows[17] = '{1'b0, 1'b1, DOWN, 8'h00, 7'h05, 5'h1a, 7'h05, 5'h1a, 2'h0, 2'h1, 8'h00};
    rows[18] = '{1'b0, 1'b1, HOME, 8'h00, 7'h14, 5'h0a, 7'h00, 5'h00, 2'h0, 2'h0, 8'h00};
    rows[19] = '{1'b0, 1'b1, XP, 8'h41, 7'h05, 5'h03, 7'h06, 5'h03, 2'h1, 2'h0, 8'hc1};
    repeat (5) @(negedge clk_sys_i);
    reset_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("reset outputs", 0, {rr_o, wr_o, mem_data_o, col_o, row_o, step_o, busy_o});
    foreach (rows[i])
      run_row(rows[i]);
    // Host home clears both counters directly
    place(7'h14, 5'h0a);
    hc <= '{1'b1, 1'b1, 1'b0, 7'h00, 5'h00};
    @(negedge clk_sys_i);
    hc <= '0;
    chk("host home", 0, {col_o, row_o, busy_o});
    // Second strobe while busy is ignored
    place(7'h00, 5'h00);
    bright <= 1'b1;
    char_q <= 8'h41;
    go_kb <= 1'b1;
    @(negedge clk_sys_i);
    go_kb <= 1'b0;
    n_wr = 0;
    repeat (150) @(negedge clk_sys_i);
    go_kb <= 1'b1;
    @(negedge clk_sys_i);
    go_kb <= 1'b0;
    wait_idle();
    chk("busy refusal", {2'h1, 7'h01}, {n_wr[1:0], col_o});
    // Repeat key recycles the sequencer until released
    place(7'h00, 5'h00);
    cmd <= RPT_RT;
    go_kb <= 1'b1;
    @(negedge clk_sys_i);
    go_kb <= 1'b0;
    n = 0;
    while (col_o !== 7'h03 && n < 6000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("repeat moves", 7'h03, col_o);
    cmd <= NO_CMD;
    wait_idle();
    col_seen = col_o;
    repeat (400) @(negedge clk_sys_i);
    chk("repeat stopped", {7'h03, 1'b0}, {col_o, busy_o});
    chk("repeat settled", col_seen, col_o);
    // Refresh blanking of control codes
    refresh_char <= 8'h0d;
    @(negedge clk_sys_i);
    chk("blank return", 1, blank_o);
    refresh_char <= 8'h41;
    @(negedge clk_sys_i);
    chk("blank printable", 0, blank_o);
    close_out();
  end

  // Hang guard, well beyond the expected run length
  initial
  begin
    repeat (80000) @(posedge clk_sys_i);
    n_mismatch++;
    close_out();
  end
endmodule
